// >>> src/rsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_top (
   input wire logic i_ref_clk, // Reference clock, 125 MHz.
   input wire logic i_rst_n, // Synchronous reset, active low.
   input wire logic i_sup_above_start, // Main supply pin above start threshold.
   input wire logic i_sup_below_start_hys, // Main supply below start threshold minus band.
   input wire logic i_sup_below_low, // Main supply below low hold threshold.
   input wire logic i_sup_above_low_hys, // Main supply above low hold threshold plus band.
   input wire logic i_sup_below_rst, // Main supply below reset threshold.
   input wire logic i_boost_above_start, // Boost voltage sense above boost start level.
   input wire logic i_cap_above_high, // Cap voltage sense above high threshold.
   input wire logic i_cap_below_low, // Cap voltage sense below low threshold.
   input wire logic i_cur_above_limit, // Resonant current sense above start-up limit.
   input wire logic i_fb_demand_low, // Feedback input asks for less power.
   input wire logic i_opto_above_target, // Optocoupler current above its target.
   input wire logic i_hv_src_hot, // HV start-up source over temperature.
   input wire logic i_protect, // Protection mode request, same clock.
   input wire logic i_nvm_valid, // Configuration memory data valid pulse.
   input wire logic [rsc_pkg::SEP_W-1:0] i_nvm_lp_level, // Low-power transition level.
   input wire logic [rsc_pkg::SEP_W-1:0] i_nvm_min_sep, // Minimum separation before burst.
   input wire logic [7:0] i_nvm_dead, // Dead time in clock cycles.
   input wire logic [7:0] i_nvm_hold, // Hold length in ticks, sets duty.
   output logic o_nvm_rd_req, // Read request to configuration memory.
   output logic o_settings_valid, // Settings are loaded.
   output logic o_hv_src_en, // HV start-up source on.
   output logic o_hv_src_reduced, // HV source charge current reduced.
   output logic o_pfc_en, // Boost converter enabled.
   output logic o_llc_run, // Resonant stage in run state.
   output logic o_high_side_gate, // High-side gate drive.
   output logic o_low_side_gate, // Low-side gate drive.
   output logic [rsc_pkg::THR_W-1:0] o_cap_high_thr, // High threshold code.
   output logic [rsc_pkg::THR_W-1:0] o_cap_low_thr, // Low threshold code.
   output logic [7:0] o_opto_bias, // Optocoupler bias code.
   output rsc_pkg::rsc_mode_e o_mode // Present operating mode.
);
   import rsc_pkg::*;

   typedef struct packed {
      rsc_state_e state;
      rsc_mode_e mode;
      logic hv;
      logic reduced;
      logic settings_valid;
      logic pfc_en;
      logic ramp;
      logic phase;
      logic hold;
      logic [1:0] half;
      logic [7:0] hold_cnt;
      logic [7:0] tick_cnt;
      logic [SEP_W-1:0] sep;
      logic [7:0] bias;
      logic [SEP_W-1:0] lp_level;
      logic [SEP_W-1:0] min_sep;
      logic [7:0] dead;
      logic [7:0] hold_len;
      logic [THR_W-1:0] thr_hi;
      logic [THR_W-1:0] thr_lo;
   } rsc_top_s;

   rsc_top_s q, d;
   logic [CMP_N-1:0] cmp_raw;
   logic [CMP_N-1:0] cmp;
   logic tick;
   logic paused;
   logic switching;

   // ==========================================================================
   // Helpers
   // ==========================================================================
   // Saturating one-step move of an 8-bit code.
   function automatic logic [7:0] step8(input logic [7:0] v, input logic up);
      if (up) begin
         return (v == 8'hFF) ? v : v + 8'h01;
      end
      return (v == 8'h00) ? v : v - 8'h01;
   endfunction

   // Saturating addition of two separation codes.
   function automatic logic [SEP_W-1:0] add_sat(input logic [SEP_W-1:0] a,
                                                input logic [SEP_W-1:0] b);
      logic [SEP_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[SEP_W] ? SEP_MAX : s[SEP_W-1:0];
   endfunction

   // Full start-over state, shared by reset and by supply collapse.
   function automatic rsc_top_s init_state();
      rsc_top_s s;
      s = '0;
      s.state = ST_CHARGE;
      s.mode = MODE_HP;
      s.hv = 1'b1;
      s.sep = SEP_RST;
      s.bias = BIAS_RST;
      s.lp_level = LP_LEVEL_RST;
      s.min_sep = MIN_SEP_RST;
      s.dead = DEAD_RST;
      s.hold_len = HOLD_RST;
      s.thr_hi = CAP_MID;
      s.thr_lo = CAP_MID;
      return s;
   endfunction

   // ==========================================================================
   // Input synchronisation
   // ==========================================================================
   // All comparators are asynchronous to the clock, so all go through the filter.
   assign cmp_raw = {i_hv_src_hot, i_opto_above_target, i_fb_demand_low, i_cur_above_limit,
                     i_cap_below_low, i_cap_above_high, i_boost_above_start, i_sup_below_rst,
                     i_sup_above_low_hys, i_sup_below_low, i_sup_below_start_hys,
                     i_sup_above_start};

   rsc_sync #(.W(CMP_N)) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_async(cmp_raw),
      .o_sync(cmp)
   );

   // ==========================================================================
   // Sequencer
   // ==========================================================================
   // Burst pause is the no-switching part of burst mode while demand is low.
   assign tick = (q.tick_cnt == TICK_LAST);
   assign paused = (q.state == ST_RUN) && (q.mode == MODE_BURST) && cmp[C_FB_LOW];
   assign switching = (q.state == ST_RUN) && !q.hold && !paused;

   // Next state of the whole sequencer.
   always_comb begin
      logic hyst_start;
      d = q;
      hyst_start = q.hv;
      if (cmp[C_START]) begin
         hyst_start = 1'b0;
      end else if (cmp[C_START_HYS]) begin
         hyst_start = 1'b1;
      end
      d.tick_cnt = tick ? 8'h00 : q.tick_cnt + 8'h01;
      d.reduced = cmp[C_HOT];
      // Thresholds sit symmetrically about the centre; widest span is maximum power.
      d.thr_hi = CAP_MID + {1'b0, q.sep};
      d.thr_lo = CAP_MID - {1'b0, q.sep};
      unique case (q.state)
         ST_CHARGE: begin
            d.hv = 1'b1;
            if (cmp[C_START]) begin
               d.hv = 1'b0;
               d.state = ST_LOAD;
            end
         end
         ST_LOAD: begin
            d.hv = hyst_start;
            if (i_nvm_valid) begin
               d.lp_level = i_nvm_lp_level;
               d.min_sep = i_nvm_min_sep;
               d.dead = i_nvm_dead;
               d.hold_len = i_nvm_hold;
               d.settings_valid = 1'b1;
               d.pfc_en = 1'b1;
               d.state = ST_PFC;
            end
         end
         ST_PFC: begin
            d.hv = hyst_start;
            if (cmp[C_BOOST]) begin
               d.state = ST_RUN;
               d.mode = MODE_HP;
               d.ramp = 1'b1;
               d.sep = SEP_RST;
               d.phase = 1'b0;
               d.hold = 1'b0;
               d.half = 2'h0;
            end
         end
         ST_PROTECT: begin
            d.hv = hyst_start;
            if (!i_protect) begin
               d.pfc_en = 1'b1;
               d.state = ST_PFC;
            end
         end
         ST_RUN: begin
            if (i_protect) begin
               d.state = ST_PROTECT;
               d.pfc_en = 1'b0;
               d.hold = 1'b0;
            end else begin
               // The auxiliary winding feeds the supply, except in a long burst pause.
               d.hv = 1'b0;
               if (paused) begin
                  d.hv = cmp[C_LOW] ? 1'b1 : (cmp[C_LOW_HYS] ? 1'b0 : q.hv);
               end
               // Capacitor window: each crossing hands the bridge to the other side, but outside MODE_HP a low crossing at HALF_LAST starts a hold.
               if (switching && !q.phase && cmp[C_CAP_LO]) begin
                  if (q.mode != MODE_HP && q.half == HALF_LAST) begin
                     d.hold = 1'b1;
                     d.hold_cnt = q.hold_len;
                     d.half = 2'h0;
                  end else begin
                     d.phase = 1'b1;
                     d.half = (q.mode != MODE_HP) ? q.half + 2'h1 : 2'h0;
                  end
               end else if (switching && q.phase && cmp[C_CAP_HI]) begin
                  d.phase = 1'b0;
                  d.half = (q.mode != MODE_HP) ? q.half + 2'h1 : 2'h0;
               end
               if (q.hold && tick) begin
                  if (q.hold_cnt == 8'h00) begin
                     d.hold = 1'b0;
                  end else begin
                     d.hold_cnt = q.hold_cnt - 8'h01;
                  end
               end
               if (tick) begin
                  d.bias = step8(q.bias, !cmp[C_OPTO]);
                  if (q.ramp) begin
                     if (cmp[C_FB_LOW]) begin
                        d.ramp = 1'b0;
                     end else if (!cmp[C_CUR]) begin
                        d.sep = step8(q.sep, 1'b1);
                     end
                  end else if (!paused) begin
                     d.sep = step8(q.sep, !cmp[C_FB_LOW]);
                  end
                  unique case (q.mode)
                     MODE_HP: begin
                        if (!q.ramp && q.sep < q.lp_level) begin
                           d.mode = MODE_LP;
                           d.sep = add_sat(q.sep, LP_BOOST);
                           d.half = 2'h0;
                        end
                     end
                     MODE_LP: begin
                        if (q.sep <= q.min_sep) begin
                           d.mode = MODE_BURST;
                        end else if ({1'b0, q.sep} > {1'b0, q.lp_level} + {1'b0, LP_BOOST}) begin
                           d.mode = MODE_HP;
                           d.hold = 1'b0;
                        end
                     end
                     MODE_BURST: begin
                        if ({1'b0, q.sep} > {1'b0, q.min_sep} + {1'b0, LP_BOOST}) begin
                           d.mode = MODE_LP;
                        end
                     end
                     default: begin
                        d.mode = MODE_HP;
                     end
                  endcase
               end
            end
         end
      endcase
      // Supply collapse beats every other event and forgets the loaded settings.
      if (cmp[C_RST]) begin
         d = init_state();
      end
   end

   // State register.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q <= init_state();
      end else begin
         q <= d;
      end
   end

   // ==========================================================================
   // Gate drive
   // ==========================================================================
   rsc_gate_if u_gif ();

   // Requests are exclusive by construction; the driver adds the dead time.
   assign u_gif.req_ls = switching && !q.phase;
   assign u_gif.req_hs = switching && q.phase;
   assign u_gif.dead = q.dead;

   rsc_gate_drv u_drv (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .gif(u_gif)
   );

   // Output mapping.
   assign o_high_side_gate = u_gif.hs_on;
   assign o_low_side_gate = u_gif.ls_on;
   assign o_nvm_rd_req = (q.state == ST_LOAD);
   assign o_settings_valid = q.settings_valid;
   assign o_hv_src_en = q.hv;
   assign o_hv_src_reduced = q.reduced;
   assign o_pfc_en = q.pfc_en;
   assign o_llc_run = (q.state == ST_RUN);
   assign o_cap_high_thr = q.thr_hi;
   assign o_cap_low_thr = q.thr_lo;
   assign o_opto_bias = q.bias;
   assign o_mode = q.mode;

   // ==========================================================================
   // Checks
   // ==========================================================================
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   a_charge_src_on: assert property (
      (q.state == ST_CHARGE && !cmp[C_START]) |=> q.hv) else $error("source off while charging");
   a_cfg_before_pfc: assert property (
      q.pfc_en |-> q.settings_valid) else $error("boost enabled before settings");
   a_llc_waits_boost: assert property (
      $rose(q.state == ST_RUN) |-> $past(cmp[C_BOOST]) && $past(q.pfc_en))
      else $error("resonant stage started early");
   a_run_src_off: assert property (
      (q.state == ST_RUN && !paused && !cmp[C_RST] && !i_protect) |=> !q.hv)
      else $error("source on while running");
   a_protect_hold: assert property (
      (q.state == ST_PROTECT && cmp[C_START] && !cmp[C_RST]) |=> !q.hv)
      else $error("no hold at start threshold");
   a_burst_low_hold: assert property (
      (paused && cmp[C_LOW] && !cmp[C_RST] && !i_protect) |=> q.hv)
      else $error("no hold at low threshold");
   a_restart_full: assert property (
      cmp[C_RST] |=> (q.state == ST_CHARGE && !q.settings_valid && !q.pfc_en) [*1])
      else $error("no full restart");
   a_high_to_low: assert property (
      (switching && q.phase && cmp[C_CAP_HI] && !cmp[C_RST] && !i_protect) |=> !q.phase)
      else $error("high side kept past high threshold");
   a_low_to_high: assert property (
      (switching && !q.phase && cmp[C_CAP_LO] && q.mode == MODE_HP && !cmp[C_RST]
       && !i_protect) |=> q.phase ##2 !o_low_side_gate)
      else $error("low side kept past low threshold");
   a_thr_span: assert property (
      !cmp[C_RST] |=> (q.thr_hi == CAP_MID + {1'b0, $past(q.sep)})
      && (q.thr_lo == CAP_MID - {1'b0, $past(q.sep)}))
      else $error("thresholds not centred on separation");
   a_opto_down: assert property (
      (q.state == ST_RUN && tick && cmp[C_OPTO] && q.bias != 8'h00 && !cmp[C_RST] && !i_protect)
      |=> q.bias == $past(q.bias) - 8'h01) else $error("bias not lowered");
   a_ramp_pause: assert property (
      (q.state == ST_RUN && q.ramp && cmp[C_CUR] && !cmp[C_RST]) |=> q.sep == $past(q.sep))
      else $error("ramp advanced above current limit");
   a_lp_boost: assert property (
      (q.mode == MODE_HP ##1 q.mode == MODE_LP) |-> q.sep > $past(q.sep))
      else $error("no boost entering low power");
endmodule // rsc_top
`default_nettype wire

// >>> src/rsc_pkg.sv
// ==========================================================================
// Shared constants and types of the resonant start-up sequencer.
// ==========================================================================
package rsc_pkg;
   // Reference clock and the slow regulation tick derived from it.
   localparam int CLK_HZ = 125_000_000;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

   // Widths of the separation code and the threshold codes.
   localparam int SEP_W = 8;
   localparam int THR_W = 9;

   // Threshold centre and separation limits; the largest separation is maximum power.
   localparam logic [8:0] CAP_MID = 9'h100;
   localparam logic [7:0] SEP_RST = 8'h00;
   localparam logic [7:0] SEP_MAX = 8'hFF;
   localparam logic [7:0] LP_BOOST = 8'h10;
   localparam logic [7:0] BIAS_RST = 8'h80;
   localparam logic [1:0] HALF_LAST = 2'h2;

   // Values held until the configuration memory has been read.
   localparam logic [7:0] DEAD_RST = 8'h04;
   localparam logic [7:0] LP_LEVEL_RST = 8'h40;
   localparam logic [7:0] MIN_SEP_RST = 8'h08;
   localparam logic [7:0] HOLD_RST = 8'h10;

   // Bit positions in the synchronised comparator vector.
   localparam int C_START = 0;
   localparam int C_START_HYS = 1;
   localparam int C_LOW = 2;
   localparam int C_LOW_HYS = 3;
   localparam int C_RST = 4;
   localparam int C_BOOST = 5;
   localparam int C_CAP_HI = 6;
   localparam int C_CAP_LO = 7;
   localparam int C_CUR = 8;
   localparam int C_FB_LOW = 9;
   localparam int C_OPTO = 10;
   localparam int C_HOT = 11;
   localparam int CMP_N = 12;

   typedef enum logic [2:0] {ST_CHARGE, ST_LOAD, ST_PFC, ST_RUN, ST_PROTECT} rsc_state_e;
   typedef enum logic [1:0] {MODE_HP, MODE_LP, MODE_BURST} rsc_mode_e;
endpackage

// >>> src/rsc_gate_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Gate requests from the sequencer to the non-overlap driver.
// ==========================================================================
interface rsc_gate_if;
   logic req_hs;
   logic req_ls;
   logic [7:0] dead;
   logic hs_on;
   logic ls_on;
   modport ctrl (output req_hs, output req_ls, output dead, input hs_on, input ls_on);
   modport drv (input req_hs, input req_ls, input dead, output hs_on, output ls_on);
endinterface
`default_nettype wire

// >>> src/rsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Three-stage synchroniser; a change is taken once stages two and three agree.
// ==========================================================================
module rsc_sync #(
   parameter int W = 12
) (
   input wire logic i_ref_clk, // Reference clock.
   input wire logic i_rst_n, // Synchronous reset, active low.
   input wire logic [W-1:0] i_async, // Comparator levels from the analog side.
   output logic [W-1:0] o_sync // Filtered levels in the clock domain.
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } rsc_sync_s;
   rsc_sync_s q, d;

   // Stage one feeds only stage two, so no logic ever sees a metastable value.
   always_comb begin
      d = q;
      d.s1 = i_async;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < W; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.o[i] = q.s3[i];
         end
      end
   end

   // State register.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_sync = q.o;
endmodule // rsc_sync
`default_nettype wire

// >>> src/rsc_gate_drv.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Half-bridge gate driver with a dead time between the two sides.
// ==========================================================================
module rsc_gate_drv (
   input wire logic i_ref_clk, // Reference clock.
   input wire logic i_rst_n, // Synchronous reset, active low.
   rsc_gate_if.drv gif // Requests in, gate states out.
);
   typedef struct packed {
      logic hs;
      logic ls;
      logic [7:0] cnt;
   } rsc_drv_s;
   rsc_drv_s q, d;

   // A withdrawn side drops at once; the other side only follows after the dead count.
   always_comb begin
      d = q;
      if ((q.hs && !gif.req_hs) || (q.ls && !gif.req_ls)) begin
         d.hs = 1'b0;
         d.ls = 1'b0;
         d.cnt = gif.dead;
      end else if (!q.hs && !q.ls) begin
         if (q.cnt != 8'h00) begin
            d.cnt = q.cnt - 8'h01;
         end else if (gif.req_hs) begin
            d.hs = 1'b1;
         end else if (gif.req_ls) begin
            d.ls = 1'b1;
         end
      end
   end

   // State register.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign gif.hs_on = q.hs;
   assign gif.ls_on = q.ls;

   // ==========================================================================
   // Checks
   // ==========================================================================
   a_no_overlap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      !(q.hs && q.ls)) else $error("both gates on together");
   a_dead_gap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      ($fell(q.ls) && gif.dead != 8'h00) |-> !q.hs ##1 !q.hs)
      else $error("high side on without dead time");
endmodule // rsc_gate_drv
`default_nettype wire

// >>> bench/rsc_tank_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Resonant tank as seen through the cap sense divider and its comparators.
// ==========================================================================
module rsc_tank_model (
   input wire logic i_ref_clk, // Reference clock.
   input wire logic i_hs, // High-side gate.
   input wire logic i_ls, // Low-side gate.
   input wire logic [8:0] i_hi, // High threshold code.
   input wire logic [8:0] i_lo, // Low threshold code.
   output logic o_above, // Cap voltage above high threshold.
   output logic o_below // Cap voltage below low threshold.
);
   int cap_q = 256;
   // The cap keeps its charge during dead time, so crossings only follow a conducting side.
   always @(posedge i_ref_clk) begin
      if (i_hs) cap_q <= cap_q + 3;
      else if (i_ls) cap_q <= cap_q - 3;
   end
   assign o_above = cap_q > int'(i_hi);
   assign o_below = cap_q < int'(i_lo);
endmodule // rsc_tank_model
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench of the start-up sequencer.
// ==========================================================================
module tb;
   import rsc_pkg::*;
   logic i_ref_clk = 0, i_rst_n = 0, i_sup_above_start = 0, i_sup_below_start_hys = 1;
   logic i_sup_below_low = 0, i_sup_above_low_hys = 0, i_sup_below_rst = 0, i_protect = 0;
   logic i_boost_above_start = 0, i_cur_above_limit = 0, i_fb_demand_low = 0, i_nvm_valid = 0;
   logic i_opto_above_target = 0, i_hv_src_hot = 0;
   logic [7:0] i_nvm_lp_level = 8'h0C, i_nvm_min_sep = 8'h08;
   logic [7:0] i_nvm_dead = 8'h03, i_nvm_hold = 8'h02;
   wire logic i_cap_above_high, i_cap_below_low;
   logic o_nvm_rd_req, o_settings_valid, o_hv_src_en, o_hv_src_reduced, o_pfc_en, o_llc_run;
   logic o_high_side_gate, o_low_side_gate, hs_p = 0, ls_p = 0, both = 0;
   logic [8:0] o_cap_high_thr, o_cap_low_thr, s;
   logic [7:0] o_opto_bias;
   rsc_mode_e o_mode;
   int error_cnt = 0, compares = 0, cyc = 0, hs_n = 0, ls_n = 0, bias0 = 0;
   rsc_top uut (.*);
   rsc_tank_model tank (.i_ref_clk, .i_hs(o_high_side_gate), .i_ls(o_low_side_gate),
      .i_hi(o_cap_high_thr), .i_lo(o_cap_low_thr), .o_above(i_cap_above_high),
      .o_below(i_cap_below_low));
   always #4 i_ref_clk = ~i_ref_clk;
   // Gate edge counts, overlap watch and the hang limit share one clocked process.
   always @(posedge i_ref_clk) begin
      hs_p <= o_high_side_gate;
      ls_p <= o_low_side_gate;
      if (o_high_side_gate === 1'b1 && hs_p === 1'b0) hs_n++;
      if (o_low_side_gate === 1'b1 && ls_p === 1'b0) ls_n++;
      if (o_high_side_gate === 1'b1 && o_low_side_gate === 1'b1) both <= 1'b1;
      cyc++;
      if (cyc == 12000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic step(input int n = 1);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic complete_run;
      if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Settings must be loaded before the boost stage, and resonant switching waits for boost.
   task automatic t_startup;
      i_sup_above_start = 1;
      i_sup_below_start_hys = 0;
      for (int i = 0; i < 40 && o_nvm_rd_req !== 1'b1; i++) step();
      chk(o_nvm_rd_req, 1, "rd req");
      chk(o_pfc_en, 0, "pfc early");
      chk(o_hv_src_en, 0, "hv hold");
      i_nvm_valid = 1;
      step();
      i_nvm_valid = 0;
      step();
      chk(o_settings_valid, 1, "settings");
      chk(o_pfc_en, 1, "pfc on");
      step(20);
      chk(o_llc_run, 0, "llc early");
      i_boost_above_start = 1;
      for (int i = 0; i < 40 && o_llc_run !== 1'b1; i++) step();
      chk(o_llc_run, 1, "llc run");
      chk(o_hv_src_en, 0, "hv off");
   endtask
   // The tank must oscillate between the thresholds without overlap, then the ramp pauses.
   task automatic t_loop;
      step(1500);
      chk(9'(hs_n > 2), 1, "hs edges");
      chk(9'(ls_n > 2), 1, "ls edges");
      chk(9'(both), 0, "overlap");
      chk(o_cap_high_thr - 9'h100, 9'h100 - o_cap_low_thr, "symmetry");
      i_cur_above_limit = 1;
      step(10);
      s = o_cap_high_thr;
      step(400);
      chk(o_cap_high_thr, s, "ramp hold");
      i_cur_above_limit = 0;
      step(400);
      chk(9'(o_cap_high_thr > s), 1, "ramp go");
   endtask
   // Falling demand walks the load down through low power into a burst pause.
   task automatic t_lowpower;
      bias0 = o_opto_bias;
      i_opto_above_target = 1;
      i_fb_demand_low = 1;
      for (int i = 0; i < 1500 && o_mode !== MODE_LP; i++) step();
      chk(o_mode, MODE_LP, "enter lp");
      chk(o_cap_high_thr, CAP_MID + 9'(i_nvm_lp_level) - 9'h001, "hp shrink");
      s = o_cap_high_thr;
      step();
      chk(o_cap_high_thr, s + 9'(LP_BOOST), "lp boost");
      for (int i = 0; i < 3000 && o_mode !== MODE_BURST; i++) step();
      chk(o_mode, MODE_BURST, "enter burst");
      step(3);
      chk(o_high_side_gate | o_low_side_gate, 0, "burst pause");
      i_sup_below_low = 1;
      step(6);
      chk(o_hv_src_en, 1, "burst hold on");
      i_sup_below_low = 0;
      i_sup_above_low_hys = 1;
      step(6);
      chk(o_hv_src_en, 0, "burst hold off");
      chk(9'(o_opto_bias < bias0), 1, "opto bias");
   endtask
   // Protection holds the supply at start level; collapse restarts everything.
   task automatic t_protect;
      i_hv_src_hot = 1;
      step(6);
      chk(o_hv_src_reduced, 1, "hot");
      i_protect = 1;
      step(3);
      chk(o_llc_run, 0, "protect");
      i_sup_above_start = 0;
      i_sup_below_start_hys = 1;
      step(6);
      chk(o_hv_src_en, 1, "protect hv on");
      i_sup_above_start = 1;
      i_sup_below_start_hys = 0;
      step(6);
      chk(o_hv_src_en, 0, "protect hv off");
      i_sup_below_rst = 1;
      step(6);
      chk(o_settings_valid | o_pfc_en, 0, "restart");
      i_sup_below_rst = 0;
      for (int i = 0; i < 40 && o_nvm_rd_req !== 1'b1; i++) step();
      chk(o_nvm_rd_req, 1, "reload");
   endtask
   initial begin
      step(6);
      chk(o_hv_src_en, 1, "reset hv");
      chk(o_cap_high_thr, CAP_MID, "reset thr");
      chk(o_opto_bias, BIAS_RST, "reset bias");
      i_rst_n = 1;
      step(4);
      t_startup();
      t_loop();
      t_lowpower();
      t_protect();
      complete_run();
   end
endmodule // tb
`default_nettype wire
